//--- blc_ctl_model.sv
// Purpose: Memory controller model on the link side
// Assumes: Link clock stands still between frames
// Notes: hist[k] holds outputs seen just before rise k
`timescale 1ns/1ps
`default_nettype none
module blc_ctl_model (
    output logic link_ck,
    output logic link_cs_n,
    output logic [1:0] link_cmd,
    output logic link_a12,
    output logic link_odt,
    output logic [7:0] link_dq_in,
    input wire logic [7:0] link_dq_out,
    input wire logic link_dq_oe,
    input wire logic odt_term
);
    logic [9:0] hist [0:39];
    initial begin
        link_ck = 0;
        link_cs_n = 1;
        link_cmd = 2'h0;
        link_a12 = 0;
        link_odt = 0;
        link_dq_in = 8'h00;
    end
    // ==========
    // One frame: select at rise 0, command at rise cal, beats from rise wl
    task automatic burst(input logic [1:0] c, input logic a, input int cal, input int wl);
        for (int k = 0; k < 40; k++) begin
            link_cs_n <= (k != 0);
            link_cmd <= (k == cal) ? c : 2'h0;
            link_a12 <= a;
            link_odt <= k[1];
            link_dq_in <= (k >= wl && k < wl + 8) ? 8'(8'hc0 + k - wl) : ~8'(k);
            #100 link_ck <= 1;
            hist[k] = {odt_term, link_dq_oe, link_dq_out};
            #100 link_ck <= 0;
        end
        link_cs_n <= 1;
        link_cmd <= 2'h0;
    endtask : burst
endmodule : blc_ctl_model
`default_nettype wire

//--- blc_fifo.sv
// Purpose: Small FIFO holding read-return beats
// Assumes: Single clock, valid and ready on both sides
// Notes: Head word is read from the registered storage array
`timescale 1ns/1ps
`default_nettype none
module blc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [CW-1:0] count;
    } blc_fifo_t;

    blc_fifo_t s;
    blc_fifo_t next_s;
    logic push;
    logic pop;

    // ==========
    // Pointers and storage
    always_comb begin
        next_s = s;
        push = in_valid && (s.count != FULL_CNT);
        pop = out_ready && (s.count != '0);
        if (push) begin
            next_s.mem[s.wr_ptr] = in_data;
            next_s.wr_ptr = (s.wr_ptr == LAST_PTR) ? '0 : s.wr_ptr + 1'b1;
        end
        if (pop) begin
            next_s.rd_ptr = (s.rd_ptr == LAST_PTR) ? '0 : s.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_s.count = s.count + 1'b1;
        end else if (pop && !push) begin
            next_s.count = s.count - 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign in_ready = (s.count != FULL_CNT);
    assign out_valid = (s.count != '0);
    assign out_data = s.mem[s.rd_ptr];

endmodule : blc_fifo
`default_nettype wire

//--- blc_pkg.sv
// Purpose: Constants and types for the burst and latency control block
// Assumes: AXI4-Lite register access with 32-bit data, byte addresses
// Notes: Rules follow
// Operation
// - With parity on, read data start CL plus AL plus PL clocks after READ.
// - With parity on, write data are taken CWL plus AL plus PL clocks after WRITE.
// - Burst mode 00, or 01 with A12 high, gives an eight-beat burst.
// - Burst mode 01 with A12 low gives a four-beat burst chop.
// - Burst mode 10 gives a four-beat chop for every command, A12 ignored.
// - Command/address latency leaves termination sampling on the plain command timing.
// - Write data are only taken while the delay-locked loop is marked locked.
package blc_pkg;

    // ==========
    // Bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int BEAT_W = 8;
    localparam int SCHED_W = 80;
    localparam int FIFO_DEPTH = 8;
    localparam int LINK_W = 14;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========
    // Register offsets
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_LAT = 8'h04;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] REG_RDATA = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_WDATA = 8'h10;

    // ==========
    // Field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_PAR_BIT = 2;
    localparam int CTRL_CAL_EN_BIT = 3;
    localparam int CTRL_CAL_LSB = 4;
    localparam int CTRL_DLL_BIT = 7;
    localparam int LAT_CL_LSB = 0;
    localparam int LAT_AL_LSB = 8;
    localparam int LAT_PL_LSB = 16;
    localparam int LAT_CWL_LSB = 24;
    localparam int ST_FULL_BIT = 0;
    localparam int ST_EMPTY_BIT = 1;
    localparam int ST_UNDER_BIT = 2;
    localparam int ST_UNLOCK_BIT = 3;
    localparam int ST_ODT_BIT = 4;
    localparam int ST_BC4_BIT = 5;
    localparam int WD_COUNT_LSB = 8;

    // ==========
    // Reset values
    localparam logic [1:0] RST_MODE = 2'h0;
    localparam logic [2:0] RST_CAL = 3'h0;
    localparam logic [4:0] RST_CL = 5'h0b;
    localparam logic [4:0] RST_AL = 5'h00;
    localparam logic [2:0] RST_PL = 3'h4;
    localparam logic [4:0] RST_CWL = 5'h09;

    // ==========
    // Burst modes and commands
    typedef enum logic [1:0] {
        BM_FIXED8 = 2'b00,
        BM_OTF = 2'b01,
        BM_FIXED4 = 2'b10,
        BM_RSVD = 2'b11
    } blc_burst_t;

    typedef enum logic [1:0] {
        CMD_NOP = 2'b00,
        CMD_READ = 2'b01,
        CMD_WRITE = 2'b10,
        CMD_RSVD = 2'b11
    } blc_cmd_t;

    // ==========
    // Register state of the top module
    typedef struct packed {
        logic [1:0] burst_mode;
        logic parity_en;
        logic cal_en;
        logic [2:0] cal_lat;
        logic dll_locked;
        logic [4:0] cl;
        logic [4:0] al;
        logic [2:0] pl;
        logic [4:0] cwl;
        logic rd_underrun;
        logic wr_unlocked;
        logic last_bc4;
        logic [BEAT_W-1:0] last_wbeat;
        logic [7:0] wbeat_count;
        logic ck_prev;
        logic [7:0] cs_hist;
        logic [SCHED_W-1:0] rd_sched;
        logic [SCHED_W-1:0] wr_sched;
        logic odt_term;
        logic [BEAT_W-1:0] dq_out;
        logic dq_oe;
        logic awready;
        logic wready;
        logic aw_held;
        logic w_held;
        logic [ADDR_W-1:0] waddr;
        logic [DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } blc_state_t;

endpackage : blc_pkg

//--- blc_sync.sv
// Purpose: Two-stage synchroniser for the link pins
// Assumes: Inputs are asynchronous to aclk
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module blc_sync #(
    parameter int WIDTH = 14
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } blc_sync_t;

    blc_sync_t s;
    blc_sync_t next_s;

    // ==========
    // Stages
    always_comb begin
        next_s.stage1 = din;
        next_s.stage2 = s.stage1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign dout = s.stage2;

endmodule : blc_sync
`default_nettype wire

//--- blc_top.sv
// Purpose: Burst length and latency control, device side
// Assumes: Link pins asynchronous to aclk; one data beat per link clock rise
// Notes: Registers over AXI4-Lite; read beats are drained from a FIFO
`timescale 1ns/1ps
`default_nettype none
module blc_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [blc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [blc_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [blc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [blc_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic link_ck,
    input wire logic link_cs_n,
    input wire logic [1:0] link_cmd,
    input wire logic link_a12,
    input wire logic link_odt,
    input wire logic [blc_pkg::BEAT_W-1:0] link_dq_in,
    output logic [blc_pkg::BEAT_W-1:0] link_dq_out,
    output logic link_dq_oe,
    output logic odt_term
);
    import blc_pkg::*;

    // ==========
    // Helpers
    function automatic logic burst_chop(input logic [1:0] mode, input logic a12);
        logic bc4;
        bc4 = 1'b0;
        case (mode)
            BM_FIXED8: bc4 = 1'b0;
            BM_OTF: bc4 = ~a12;
            BM_FIXED4: bc4 = 1'b1;
            default: bc4 = 1'b0;
        endcase
        return bc4;
    endfunction : burst_chop

    function automatic logic [6:0] eff_latency(input logic [4:0] base, input logic [4:0] al,
        input logic [2:0] pl, input logic par);
        logic [6:0] lat;
        lat = 7'(base) + 7'(al);
        if (par) begin
            lat = lat + 7'(pl);
        end
        return lat;
    endfunction : eff_latency

    function automatic logic [SCHED_W-1:0] sched_mask(input logic [6:0] lat, input logic bc4);
        logic [SCHED_W-1:0] m;
        m = {72'h0, (bc4 ? 8'h0f : 8'hff)};
        if (lat != 7'h0) begin
            m = m << (lat - 7'h1);
        end
        return m;
    endfunction : sched_mask

    function automatic logic [DATA_W-1:0] merge_strb(input logic [DATA_W-1:0] old,
        input logic [DATA_W-1:0] nw,
        input logic [3:0] strb);
        logic [DATA_W-1:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge_strb

    function automatic logic reg_known(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] a;
        a = {addr[ADDR_W-1:2], 2'b00};
        return (a == REG_CTRL) || (a == REG_LAT) || (a == REG_STATUS) ||
               (a == REG_RDATA) || (a == REG_WDATA);
    endfunction : reg_known

    // ==========
    // Link input synchroniser
    logic [LINK_W-1:0] link_raw;
    logic [LINK_W-1:0] link_sync;

    assign link_raw = {link_ck, link_cs_n, link_cmd, link_a12, link_odt, link_dq_in};

    blc_sync #(
        .WIDTH(LINK_W)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .din(link_raw),
        .dout(link_sync)
    );

    logic lk_ck;
    logic lk_cs_n;
    logic [1:0] lk_cmd;
    logic lk_a12;
    logic lk_odt;
    logic [BEAT_W-1:0] lk_dq;

    assign lk_ck = link_sync[13];
    assign lk_cs_n = link_sync[12];
    assign lk_cmd = link_sync[11:10];
    assign lk_a12 = link_sync[9];
    assign lk_odt = link_sync[8];
    assign lk_dq = link_sync[7:0];

    // ==========
    // Read-return FIFO
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [BEAT_W-1:0] fifo_out_data;

    blc_state_t s;
    blc_state_t next_s;

    blc_fifo #(
        .WIDTH(BEAT_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(s.wdata[BEAT_W-1:0]),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // ==========
    // Next-state logic
    logic ck_rise;
    logic cs_hit;
    logic bc4;
    logic [6:0] rl;
    logic [6:0] wl;
    logic set_under;
    logic set_unlock;
    logic clr_under;
    logic clr_unlock;
    logic [ADDR_W-1:0] wa;
    logic [ADDR_W-1:0] ra;
    logic [DATA_W-1:0] ctrl_word;
    logic [DATA_W-1:0] lat_word;
    logic [DATA_W-1:0] stat_word;
    logic [DATA_W-1:0] word;

    always_comb begin
        next_s = s;
        fifo_in_valid = 1'b0;
        fifo_out_ready = 1'b0;
        set_under = 1'b0;
        set_unlock = 1'b0;
        clr_under = 1'b0;
        clr_unlock = 1'b0;
        word = '0;
        ck_rise = lk_ck && !s.ck_prev;
        next_s.ck_prev = lk_ck;
        rl = eff_latency(s.cl, s.al, s.pl, s.parity_en);
        wl = eff_latency(s.cwl, s.al, s.pl, s.parity_en);
        bc4 = burst_chop(s.burst_mode, lk_a12);
        if (s.cal_en && (s.cal_lat != 3'h0)) begin
            cs_hit = s.cs_hist[s.cal_lat - 3'h1];
        end else begin
            cs_hit = !lk_cs_n;
        end

        ctrl_word = '0;
        ctrl_word[CTRL_MODE_LSB +: 2] = s.burst_mode;
        ctrl_word[CTRL_PAR_BIT] = s.parity_en;
        ctrl_word[CTRL_CAL_EN_BIT] = s.cal_en;
        ctrl_word[CTRL_CAL_LSB +: 3] = s.cal_lat;
        ctrl_word[CTRL_DLL_BIT] = s.dll_locked;
        lat_word = '0;
        lat_word[LAT_CL_LSB +: 5] = s.cl;
        lat_word[LAT_AL_LSB +: 5] = s.al;
        lat_word[LAT_PL_LSB +: 3] = s.pl;
        lat_word[LAT_CWL_LSB +: 5] = s.cwl;
        stat_word = '0;
        stat_word[ST_FULL_BIT] = !fifo_in_ready;
        stat_word[ST_EMPTY_BIT] = !fifo_out_valid;
        stat_word[ST_UNDER_BIT] = s.rd_underrun;
        stat_word[ST_UNLOCK_BIT] = s.wr_unlocked;
        stat_word[ST_ODT_BIT] = s.odt_term;
        stat_word[ST_BC4_BIT] = s.last_bc4;

        // Link side, one step per link clock rise
        if (ck_rise) begin
            next_s.odt_term = lk_odt;
            next_s.cs_hist = {s.cs_hist[6:0], !lk_cs_n};
            next_s.rd_sched = s.rd_sched >> 1;
            next_s.wr_sched = s.wr_sched >> 1;
            if (cs_hit && (lk_cmd == CMD_READ)) begin
                next_s.rd_sched = next_s.rd_sched | sched_mask(rl, bc4);
                next_s.last_bc4 = bc4;
            end
            if (cs_hit && (lk_cmd == CMD_WRITE)) begin
                next_s.wr_sched = next_s.wr_sched | sched_mask(wl, bc4);
                next_s.last_bc4 = bc4;
            end
            if (s.rd_sched[0]) begin
                next_s.dq_oe = 1'b1;
                fifo_out_ready = 1'b1;
                if (fifo_out_valid) begin
                    next_s.dq_out = fifo_out_data;
                end else begin
                    next_s.dq_out = '0;
                    set_under = 1'b1;
                end
            end else begin
                next_s.dq_oe = 1'b0;
            end
            if (s.wr_sched[0]) begin
                if (s.dll_locked) begin
                    next_s.last_wbeat = lk_dq;
                    next_s.wbeat_count = s.wbeat_count + 8'h01;
                end else begin
                    set_unlock = 1'b1;
                end
            end
        end

        // Write address and data channels
        if (s_axi_awvalid && s.awready) begin
            next_s.awready = 1'b0;
            next_s.aw_held = 1'b1;
            next_s.waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready) begin
            next_s.wready = 1'b0;
            next_s.w_held = 1'b1;
            next_s.wdata = s_axi_wdata;
            next_s.wstrb = s_axi_wstrb;
        end
        wa = {s.waddr[ADDR_W-1:2], 2'b00};
        if (s.aw_held && s.w_held && !s.bvalid) begin
            if ((wa == REG_RDATA) && s.wstrb[0]) begin
                fifo_in_valid = 1'b1;
            end
            if (!fifo_in_valid || fifo_in_ready) begin
                next_s.aw_held = 1'b0;
                next_s.w_held = 1'b0;
                next_s.bvalid = 1'b1;
                next_s.bresp = reg_known(s.waddr) ? RESP_OKAY : RESP_SLVERR;
                if (wa == REG_CTRL) begin
                    word = merge_strb(ctrl_word, s.wdata, s.wstrb);
                    next_s.burst_mode = word[CTRL_MODE_LSB +: 2];
                    next_s.parity_en = word[CTRL_PAR_BIT];
                    next_s.cal_en = word[CTRL_CAL_EN_BIT];
                    next_s.cal_lat = word[CTRL_CAL_LSB +: 3];
                    next_s.dll_locked = word[CTRL_DLL_BIT];
                end
                if (wa == REG_LAT) begin
                    word = merge_strb(lat_word, s.wdata, s.wstrb);
                    next_s.cl = word[LAT_CL_LSB +: 5];
                    next_s.al = word[LAT_AL_LSB +: 5];
                    next_s.pl = word[LAT_PL_LSB +: 3];
                    next_s.cwl = word[LAT_CWL_LSB +: 5];
                end
                if ((wa == REG_STATUS) && s.wstrb[0]) begin
                    clr_under = s.wdata[ST_UNDER_BIT];
                    clr_unlock = s.wdata[ST_UNLOCK_BIT];
                end
            end
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
            next_s.awready = 1'b1;
            next_s.wready = 1'b1;
        end

        // Sticky flags, a new event beats a clear
        next_s.rd_underrun = (s.rd_underrun && !clr_under) || set_under;
        next_s.wr_unlocked = (s.wr_unlocked && !clr_unlock) || set_unlock;

        // Read channel
        ra = {s_axi_araddr[ADDR_W-1:2], 2'b00};
        if (s_axi_arvalid && s.arready) begin
            next_s.arready = 1'b0;
            next_s.rvalid = 1'b1;
            next_s.rresp = reg_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            case (ra)
                REG_CTRL: next_s.rdata = ctrl_word;
                REG_LAT: next_s.rdata = lat_word;
                REG_STATUS: next_s.rdata = stat_word;
                REG_WDATA: next_s.rdata = {16'h0, s.wbeat_count, s.last_wbeat};
                default: next_s.rdata = '0;
            endcase
        end
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
            next_s.arready = 1'b1;
        end
    end

    // ==========
    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.burst_mode <= RST_MODE;
            s.cal_lat <= RST_CAL;
            s.cl <= RST_CL;
            s.al <= RST_AL;
            s.pl <= RST_PL;
            s.cwl <= RST_CWL;
            s.awready <= 1'b1;
            s.wready <= 1'b1;
            s.arready <= 1'b1;
        end else if (ce) begin
            s <= next_s;
        end
    end

    // ==========
    // Outputs
    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign link_dq_out = s.dq_out;
    assign link_dq_oe = s.dq_oe;
    assign odt_term = s.odt_term;

endmodule : blc_top
`default_nettype wire

//--- blc_top_properties.sv
// Purpose: Handshake and termination checks for blc_top
// Assumes: Bound to every blc_top instance
// Notes: Burst timing is judged by the bench
`timescale 1ns/1ps
`default_nettype none
module blc_top_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [blc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [blc_pkg::DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic link_ck,
    input wire logic link_odt,
    input wire logic odt_term
);
    import blc_pkg::*;
    logic ck_d;
    logic odt_cap;
    logic [3:0] since;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ==========
    // Link rise tracker
    always_ff @(posedge aclk) begin
        ck_d <= link_ck;
        if (!aresetn) begin
            since <= 4'hf;
            odt_cap <= 1'b0;
        end else if (link_ck && !ck_d) begin
            odt_cap <= link_odt;
            since <= 4'h0;
        end else if (since != 4'hf) begin
            since <= since + 4'h1;
        end
    end
    // ==========
    // Properties
    sequence s_ar;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_aw;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    property p_ar; s_ar |=> s_axi_rvalid && !s_axi_arready; endproperty
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    property p_rdone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##0 s_axi_arready; endproperty
    property p_unmap; s_ar ##0 s_axi_araddr > 8'h13 |=> s_axi_rresp == RESP_SLVERR; endproperty
    property p_aw; s_aw |=> !s_axi_awready && !s_axi_wready; endproperty
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready; endproperty
    property p_rst; $rose(aresetn) |-> s_axi_awready && s_axi_wready && s_axi_arready; endproperty
    property p_odt; since == 4'h6 |-> odt_term == odt_cap; endproperty
    a_ar: assert property (p_ar) else $error("read answer late");
    a_rhold: assert property (p_rhold) else $error("read data moved");
    a_rdone: assert property (p_rdone) else $error("read not released");
    a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
    a_aw: assert property (p_aw) else $error("write ready stayed high");
    a_bhold: assert property (p_bhold) else $error("write response moved");
    a_bdone: assert property (p_bdone) else $error("write not released");
    a_rst: assert property (p_rst) else $error("ready low after reset");
    a_odt: assert property (p_odt) else $error("termination mismatch");
endmodule : blc_top_properties
bind blc_top blc_top_properties u_props (.*);
`default_nettype wire

//--- tb_blc_top.sv
// Purpose: Self-checking bench for blc_top
// Assumes: Link partner in blc_ctl_model
// Notes: CL3 AL1 PL2 CWL2 keep bursts short
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, w) begin tests_run++; if ((g) !== (w)) begin err_total++; $display("Error %0t: got %h want %h", $time, g, w); end end
module tb_blc_top;
    import blc_pkg::*;
    logic aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr, link_dq_in, link_dq_out, wcnt;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [1:0] s_axi_bresp, s_axi_rresp, link_cmd;
    logic link_ck, link_cs_n, link_a12, link_odt, link_dq_oe, odt_term;
    int err_total, tests_run, cycles;
    blc_top dut (.*);
    blc_ctl_model lm (.*);
    // ==========
    // Bus tasks
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_bready <= 1;
        fork
            begin do @(posedge aclk); while (s_axi_awready !== 1); s_axi_awvalid <= 0; end
            begin do @(posedge aclk); while (s_axi_wready !== 1); s_axi_wvalid <= 0; end
        join
        do @(posedge aclk); while (s_axi_bvalid !== 1);
        s_axi_bready <= 0;
        `CHK(s_axi_bresp, er)
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_arvalid <= 1;
        s_axi_araddr <= a;
        s_axi_rready <= 1;
        do @(posedge aclk); while (s_axi_arready !== 1);
        s_axi_arvalid <= 0;
        do @(posedge aclk); while (s_axi_rvalid !== 1);
        s_axi_rready <= 0;
        d = s_axi_rdata;
        `CHK(s_axi_rresp, er)
    endtask : rd
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        rd(a, d, er);
        `CHK(d, e)
    endtask : rc
    // ==========
    // Burst helpers
    task automatic rd_burst(input logic [1:0] m, input logic a, input logic p, input int cal,
        input int len, input bit push);
        int rl;
        logic [31:0] d;
        rl = p ? 6 : 4;
        for (int j = 0; j < len; j++) if (push) wr(REG_RDATA, 32'ha0 + j, RESP_OKAY);
        wr(REG_LAT, 32'h02020103, RESP_OKAY);
        wr(REG_CTRL, {24'h0, 1'b1, cal[2:0], cal != 0, p, m}, RESP_OKAY);
        lm.burst(CMD_READ, a, cal, 99);
        for (int j = 0; j < 24; j++) begin
            `CHK(lm.hist[j + cal + 1][8], j >= rl && j < rl + len)
            if (j >= rl && j < rl + len) `CHK(lm.hist[j + cal + 1][7:0], 8'(8'ha0 + j - rl))
            `CHK(lm.hist[j + 1][9], j[1])
        end
        rd(REG_STATUS, d, RESP_OKAY);
        `CHK(d[ST_EMPTY_BIT], 1'b1)
        `CHK(d[ST_BC4_BIT], len == 4)
    endtask : rd_burst
    task automatic wr_burst(input logic p, input logic dll);
        logic [31:0] d;
        wr(REG_CTRL, {24'h0, dll, 4'h0, p, 2'b00}, RESP_OKAY);
        lm.burst(CMD_WRITE, 1'b1, 0, p ? 5 : 3);
        if (dll) wcnt += 8'h08;
        rd(REG_WDATA, d, RESP_OKAY);
        `CHK(d[15:0], {wcnt, 8'hc7})
        rd(REG_STATUS, d, RESP_OKAY);
        `CHK(d[ST_UNLOCK_BIT], !dll)
        wr(REG_STATUS, 32'h8, RESP_OKAY);
        rd(REG_STATUS, d, RESP_OKAY);
        `CHK(d[ST_UNLOCK_BIT], 1'b0)
    endtask : wr_burst
    // ==========
    // Scenarios
    task automatic t_regs;
        rc(REG_CTRL, 32'h0, RESP_OKAY);
        rc(REG_LAT, 32'h0904000b, RESP_OKAY);
        rc(8'h20, 32'h0, RESP_SLVERR);
        wr(8'h20, 32'h1, RESP_SLVERR);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_fifo_bl8;
        logic [31:0] d;
        for (int j = 0; j < 8; j++) wr(REG_RDATA, 32'ha0 + j, RESP_OKAY);
        rd(REG_STATUS, d, RESP_OKAY);
        `CHK(d[ST_FULL_BIT], 1'b1)
        rd_burst(BM_FIXED8, 1'b0, 1'b0, 0, 8, 0);
        $display("t_fifo_bl8 done");
    endtask : t_fifo_bl8
    task automatic t_bursts;
        rd_burst(BM_OTF, 1'b1, 1'b1, 0, 8, 1);
        rd_burst(BM_OTF, 1'b0, 1'b0, 0, 4, 1);
        rd_burst(BM_FIXED4, 1'b1, 1'b0, 3, 4, 1);
        $display("t_bursts done");
    endtask : t_bursts
    task automatic t_writes;
        wr_burst(1'b1, 1'b1);
        wr_burst(1'b0, 1'b0);
        $display("t_writes done");
    endtask : t_writes
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : tally_and_finish
    // ==========
    // Clock, watchdog and main sequence
    initial begin
        aclk = 0;
        forever #12.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 30000) begin
            err_total++;
            $display("Error %0t: timeout", $time);
            tally_and_finish;
        end
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot, wcnt} = 0;
        ce = 1;
        s_axi_wstrb = 4'hf;
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        repeat (4) @(posedge aclk);
        t_regs;
        t_fifo_bl8;
        t_bursts;
        t_writes;
        tally_and_finish;
    end
endmodule : tb_blc_top
`default_nettype wire
